// *** hw/asrc_pkg.sv ***
package asrc_pkg;

  typedef logic [31:0] asrc_word_t;
  typedef logic [7:0]  asrc_byte_t;

  // Register byte offsets, low address byte only
  localparam asrc_byte_t ASRC_OFF_MODE = 8'h00;
  localparam asrc_byte_t ASRC_OFF_ERR  = 8'h04;
  localparam asrc_byte_t ASRC_OFF_RBUF = 8'h08;
  localparam asrc_byte_t ASRC_OFF_BRC  = 8'h0c;
  localparam asrc_byte_t ASRC_OFF_TXD  = 8'h10;
  localparam asrc_byte_t ASRC_OFF_STAT = 8'h14;

  // Operation mode register fields
  localparam int ASRC_MODE_PWR = 7;
  localparam int ASRC_MODE_TXE = 6;
  localparam int ASRC_MODE_RXE = 5;
  localparam int ASRC_MODE_PSH = 4;
  localparam int ASRC_MODE_PSL = 3;
  localparam int ASRC_MODE_CL  = 2;
  localparam int ASRC_MODE_SL  = 1;
  localparam asrc_byte_t ASRC_MODE_RST = 8'h01;

  // Baud control fields: [7:5] base select, [4:0] divider
  localparam int ASRC_BRC_SEL_LSB = 5;
  localparam asrc_byte_t ASRC_BRC_RST = 8'h1f;

  // Error status and status fields
  localparam int ASRC_ERR_PE = 2;
  localparam int ASRC_ERR_FE = 1;
  localparam int ASRC_ERR_OV = 0;
  localparam int ASRC_STAT_TXBUSY = 0;
  localparam int ASRC_STAT_RXFULL = 1;

  // Read wait states
  localparam logic [1:0] ASRC_RD_WAIT  = 2'h1;
  localparam logic [1:0] ASRC_ERR_WAIT = 2'h2;

  // Frame sizes
  localparam logic [3:0] ASRC_LEN7 = 4'h8;
  localparam logic [3:0] ASRC_LEN8 = 4'h9;
  localparam logic [11:0] ASRC_FRAME_IDLE = 12'hfff;

  typedef enum logic [2:0] {
    ASRC_RX_IDLE,
    ASRC_RX_START,
    ASRC_RX_DATA,
    ASRC_RX_PARITY,
    ASRC_RX_STOP
  } asrc_rx_e;

endpackage

// *** hw/asrc_half_div.sv ***
`timescale 1ns/1ps
module asrc_half_div (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic       base_tick,
  input  wire logic [4:0] divisor,
  // Output
  output logic            half_tick
);
  logic [4:0] cnt_q;
  logic [4:0] last;

  // Divisor zero wraps to a full 32-count
  assign last = divisor - 5'h01;

  // Pulse is combinational so the first half bit is k base ticks, not k plus one
  assign half_tick = run && !restart && base_tick && (cnt_q == last);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 5'h00;
    end else if (!run || restart) begin
      cnt_q <= 5'h00;
    end else if (base_tick) begin
      cnt_q <= (cnt_q == last) ? 5'h00 : cnt_q + 5'h01;
    end
  end
endmodule

// *** hw/asrc_top.sv ***
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Function
// - Power and receive enabled with line low starts frame reception at once.
// - Transmit and receive enables are resynchronised on the baud base clock.
// - Receiver always works with one stop bit; stop length affects transmit only.
// - Parity error flag follows the current parity mode selection.
// - Framing check looks only at the first stop bit position.
// - While overrun is flagged the next character is discarded.
// - Reading error status inserts two wait cycles.
// - Baud rate is the five-bit divider output divided by two.
module asrc_top (
  // Clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  asrc_pkg::asrc_word_t      haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  asrc_pkg::asrc_word_t      hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output asrc_pkg::asrc_word_t      hrdata,
  // Serial lines
  input  wire logic                 serial_receive_input,
  output logic                      serial_transmit_output
);
  import asrc_pkg::*;

  function automatic logic asrc_hit(input asrc_byte_t a, input asrc_byte_t o);
    asrc_hit = (a == o);
  endfunction

  // Parity bit for a character; mode 01 sends a zero and is never checked
  function automatic logic asrc_par(input logic [1:0] ps, input asrc_byte_t d,
                                    input logic cl);
    logic ones;
    ones = ^{d[7] & cl, d[6:0]};
    case (ps)
      2'h2:    asrc_par = ~ones;
      2'h3:    asrc_par = ones;
      default: asrc_par = 1'b0;
    endcase
  endfunction

  asrc_byte_t  mode_q;
  asrc_byte_t  brc_q;
  asrc_byte_t  rbuf_q;
  logic [2:0]  err_q;
  logic        rfull_q;
  logic        pwr;
  logic        cl;
  logic [1:0]  ps;

  assign pwr = mode_q[ASRC_MODE_PWR];
  assign cl  = mode_q[ASRC_MODE_CL];
  assign ps  = {mode_q[ASRC_MODE_PSH], mode_q[ASRC_MODE_PSL]};

  // Bus slave
  logic        dp_valid_q;
  logic        dp_write_q;
  asrc_byte_t  dp_addr_q;
  logic [1:0]  wait_q;
  asrc_word_t  hrdata_q;
  logic        addr_take;
  logic        rd_last;
  logic        wr_now;
  logic        err_clr;
  logic        rbuf_rd;
  asrc_byte_t  rd_mux;
  logic        tx_busy;

  assign addr_take = hsel && htrans[1] && hready;
  assign hreadyout = (wait_q == 2'h0);
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign rd_last   = dp_valid_q && !dp_write_q && (wait_q == 2'h1);
  assign wr_now    = dp_valid_q && dp_write_q;
  assign err_clr   = rd_last && asrc_hit(dp_addr_q, ASRC_OFF_ERR);
  assign rbuf_rd   = rd_last && asrc_hit(dp_addr_q, ASRC_OFF_RBUF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q  <= 8'h00;
      wait_q     <= 2'h0;
    end else if (addr_take) begin
      dp_valid_q <= 1'b1;
      dp_write_q <= hwrite;
      dp_addr_q  <= haddr[7:0];
      if (hwrite) begin
        wait_q <= 2'h0;
      end else if (asrc_hit(haddr[7:0], ASRC_OFF_ERR)) begin
        wait_q <= ASRC_ERR_WAIT;
      end else begin
        wait_q <= ASRC_RD_WAIT;
      end
    end else begin
      if (hreadyout) begin
        dp_valid_q <= 1'b0;
      end
      if (wait_q != 2'h0) begin
        wait_q <= wait_q - 2'h1;
      end
    end
  end

  always_comb begin
    case (dp_addr_q)
      ASRC_OFF_MODE: rd_mux = mode_q;
      ASRC_OFF_ERR:  rd_mux = {5'h00, err_q};
      ASRC_OFF_RBUF: rd_mux = rbuf_q;
      ASRC_OFF_BRC:  rd_mux = brc_q;
      ASRC_OFF_STAT: rd_mux = {6'h00, rfull_q, tx_busy};
      default:       rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_last) begin
      hrdata_q <= {24'h00_0000, rd_mux};
    end
  end

  // Bit zero is stored as written so software sees its own value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= ASRC_MODE_RST;
      brc_q  <= ASRC_BRC_RST;
    end else if (wr_now) begin
      if (asrc_hit(dp_addr_q, ASRC_OFF_MODE)) begin
        mode_q <= hwdata[7:0];
      end
      if (asrc_hit(dp_addr_q, ASRC_OFF_BRC)) begin
        brc_q <= hwdata[7:0];
      end
    end
  end

  // Base clock prescaler: hclk divided by two to the select
  logic [6:0] pre_q;
  logic [7:0] pre_mask;
  logic       base_tick_q;

  assign pre_mask = (8'h01 << brc_q[7:ASRC_BRC_SEL_LSB]) - 8'h01;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q       <= 7'h00;
      base_tick_q <= 1'b0;
    end else if (!pwr) begin
      pre_q       <= 7'h00;
      base_tick_q <= 1'b0;
    end else begin
      pre_q       <= pre_q + 7'h01;
      base_tick_q <= ((pre_q & pre_mask[6:0]) == pre_mask[6:0]);
    end
  end

  // Enables take effect only on a base clock tick
  logic tx_en_s_q;
  logic rx_en_s_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_en_s_q <= 1'b0;
      rx_en_s_q <= 1'b0;
    end else if (!pwr) begin
      tx_en_s_q <= 1'b0;
      rx_en_s_q <= 1'b0;
    end else if (base_tick_q) begin
      tx_en_s_q <= mode_q[ASRC_MODE_TXE];
      rx_en_s_q <= mode_q[ASRC_MODE_RXE];
    end
  end

  // Half-bit dividers: index 0 receive, 1 transmit
  logic [1:0] half_tick;
  logic [1:0] div_restart;
  logic [1:0] div_run;

  assign div_run = {tx_en_s_q, rx_en_s_q};

  for (genvar i = 0; i < 2; i++) begin : g_div
    asrc_half_div u_div (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .run       (div_run[i]),
      .restart   (div_restart[i]),
      .base_tick (base_tick_q),
      .divisor   (brc_q[4:0]),
      .half_tick (half_tick[i])
    );
  end

  // Receiver
  asrc_rx_e    rx_state_q;
  logic        rx_phase_q;
  logic [3:0]  rx_cnt_q;
  asrc_byte_t  rx_sh_q;
  logic        rx_par_q;
  logic        rx_samp;
  logic        rx_go;
  logic        rx_done;
  asrc_byte_t  rx_data;

  assign rx_go   = (rx_state_q == ASRC_RX_IDLE) && rx_en_s_q && !serial_receive_input;
  assign rx_samp = half_tick[0] && rx_phase_q;
  assign rx_done = (rx_state_q == ASRC_RX_STOP) && rx_samp;
  assign rx_data = cl ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
  assign div_restart[0] = rx_go;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_q <= ASRC_RX_IDLE;
      rx_phase_q <= 1'b0;
      rx_cnt_q   <= 4'h0;
      rx_sh_q    <= 8'h00;
      rx_par_q   <= 1'b0;
    end else if (!rx_en_s_q) begin
      rx_state_q <= ASRC_RX_IDLE;
      rx_phase_q <= 1'b0;
    end else begin
      // First half tick lands mid start bit, then every second one
      if (rx_go) begin
        rx_phase_q <= 1'b1;
      end else if (half_tick[0]) begin
        rx_phase_q <= !rx_phase_q;
      end
      case (rx_state_q)
        ASRC_RX_IDLE: begin
          if (rx_go) begin
            rx_state_q <= ASRC_RX_START;
          end
        end
        ASRC_RX_START: begin
          if (rx_samp) begin
            rx_cnt_q   <= 4'h0;
            rx_state_q <= serial_receive_input ? ASRC_RX_IDLE : ASRC_RX_DATA;
          end
        end
        ASRC_RX_DATA: begin
          if (rx_samp) begin
            rx_sh_q  <= {serial_receive_input, rx_sh_q[7:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == (cl ? 4'h7 : 4'h6)) begin
              rx_state_q <= (ps != 2'h0) ? ASRC_RX_PARITY : ASRC_RX_STOP;
            end
          end
        end
        ASRC_RX_PARITY: begin
          if (rx_samp) begin
            rx_par_q   <= serial_receive_input;
            rx_state_q <= ASRC_RX_STOP;
          end
        end
        ASRC_RX_STOP: begin
          if (rx_samp) begin
            rx_state_q <= ASRC_RX_IDLE;
          end
        end
        default: rx_state_q <= ASRC_RX_IDLE;
      endcase
    end
  end

  // Error flags and receive buffer; a new event beats a clearing read
  logic pe_ev;
  logic fe_ev;
  logic ov_ev;
  logic discard;

  assign pe_ev   = rx_done && mode_q[ASRC_MODE_PSH] &&
                   (rx_par_q != asrc_par(ps, rx_data, cl));
  assign fe_ev   = rx_done && !serial_receive_input;
  assign ov_ev   = rx_done && rfull_q && !rbuf_rd;
  assign discard = ov_ev || err_q[ASRC_ERR_OV];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_q <= 3'h0;
    end else begin
      err_q[ASRC_ERR_PE] <= pe_ev || (err_q[ASRC_ERR_PE] && !err_clr);
      err_q[ASRC_ERR_FE] <= fe_ev || (err_q[ASRC_ERR_FE] && !err_clr);
      err_q[ASRC_ERR_OV] <= ov_ev || (err_q[ASRC_ERR_OV] && !err_clr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rbuf_q  <= 8'h00;
      rfull_q <= 1'b0;
    end else if (rx_done && !discard) begin
      rbuf_q  <= rx_data;
      rfull_q <= 1'b1;
    end else if (rbuf_rd) begin
      rfull_q <= 1'b0;
    end
  end

  // Transmitter
  logic [11:0] tx_sh_q;
  logic [3:0]  tx_left_q;
  logic        tx_phase_q;
  logic [11:0] tx_frame;
  logic [3:0]  tx_pos;
  logic [3:0]  tx_len;
  logic        tx_load;
  logic        tx_shift;

  assign tx_busy  = (tx_left_q != 4'h0);
  assign tx_load  = wr_now && asrc_hit(dp_addr_q, ASRC_OFF_TXD) && tx_en_s_q && !tx_busy;
  assign tx_shift = half_tick[1] && tx_phase_q && tx_busy;
  assign div_restart[1] = tx_load;

  always_comb begin
    tx_frame    = ASRC_FRAME_IDLE;
    tx_frame[0] = 1'b0;
    tx_pos      = cl ? ASRC_LEN8 : ASRC_LEN7;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || cl) begin
        tx_frame[i + 1] = hwdata[i];
      end
    end
    if (ps != 2'h0) begin
      tx_frame[tx_pos] = asrc_par(ps, hwdata[7:0], cl);
    end
    tx_len = tx_pos + {3'h0, ps != 2'h0} + (mode_q[ASRC_MODE_SL] ? 4'h2 : 4'h1);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sh_q                <= ASRC_FRAME_IDLE;
      tx_left_q              <= 4'h0;
      tx_phase_q             <= 1'b0;
      serial_transmit_output <= 1'b1;
    end else if (!tx_en_s_q) begin
      tx_sh_q                <= ASRC_FRAME_IDLE;
      tx_left_q              <= 4'h0;
      tx_phase_q             <= 1'b0;
      serial_transmit_output <= 1'b1;
    end else if (tx_load) begin
      tx_sh_q                <= tx_frame;
      tx_left_q              <= tx_len;
      tx_phase_q             <= 1'b0;
      serial_transmit_output <= 1'b0;
    end else if (half_tick[1]) begin
      tx_phase_q <= !tx_phase_q;
      if (tx_shift) begin
        tx_sh_q                <= {1'b1, tx_sh_q[11:1]};
        tx_left_q              <= tx_left_q - 4'h1;
        serial_transmit_output <= tx_sh_q[1];
      end
    end
  end

  // Helper: cycles between two bit shifts when base clock equals hclk
  logic [6:0] gap_q;
  logic       gap_ok_q;
  logic [6:0] bit_cyc;

  assign bit_cyc = {1'b0, (brc_q[4:0] == 5'h00), brc_q[4:0]} << 1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_q    <= 7'h00;
      gap_ok_q <= 1'b0;
    end else begin
      gap_q    <= tx_shift ? 7'h00 : gap_q + 7'h01;
      gap_ok_q <= tx_shift ? !wr_now : (gap_ok_q && !wr_now && tx_en_s_q);
    end
  end

  en_sync_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (rx_en_s_q != $past(rx_en_s_q)) |-> ($past(base_tick_q) || !$past(pwr)))
    else $error("receive enable changed off a base tick");

  rx_start_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_go |=> (rx_state_q == ASRC_RX_START))
    else $error("low line with receive enabled did not start a frame");

  one_stop_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (rx_done && rx_en_s_q) |=> (rx_state_q == ASRC_RX_IDLE))
    else $error("receiver waited beyond one stop bit");

  stop_check_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (rx_done && !serial_receive_input) |=> err_q[ASRC_ERR_FE])
    else $error("low first stop bit not flagged");

  par_mode_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(err_q[ASRC_ERR_PE]) |-> $past(mode_q[ASRC_MODE_PSH] && rx_done))
    else $error("parity error set with checking off");

  ovr_keep_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (rx_done && err_q[ASRC_ERR_OV])
    |=> $stable(rbuf_q) && (rfull_q == $past(rfull_q && !rbuf_rd)))
    else $error("character stored during overrun");

  err_wait_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (addr_take && !hwrite && asrc_hit(haddr[7:0], ASRC_OFF_ERR))
    |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
    else $error("error status read without its wait cycle");

  ovr_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (rx_done && rfull_q && !rbuf_rd) |=> err_q[ASRC_ERR_OV] && $stable(rbuf_q))
    else $error("unread buffer overwritten without overrun");

  bit_time_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (tx_shift && gap_ok_q && brc_q[7:5] == 3'h0) |-> (gap_q == bit_cyc - 7'h01))
    else $error("bit time is not twice the divider count");

endmodule

// *** tb/asrc_remote.sv ***
`timescale 1ns/1ps
module asrc_remote #(
  parameter int BIT_CYC = 8
) (
  // Clock
  input  wire logic hclk,
  // Line into the device receiver
  output logic      line
);
  initial line = 1'b1;

  // Parity mode: 00 none, 01 zero bit, 10 odd, 11 even; bad flips the parity bit
  task automatic send(input logic [7:0] d, input logic [1:0] pm, input logic bad,
                      input logic stop_v);
    logic [11:0] f;
    logic        par;
    int          n;
    par = (pm == 2'h1) ? 1'b0 : (pm == 2'h2) ? ~^d : ^d;
    par = par ^ bad;
    n   = (pm == 2'h0) ? 10 : 11;
    f   = (pm == 2'h0) ? {2'h3, stop_v, d, 1'b0} : {1'b1, stop_v, par, d, 1'b0};
    for (int i = 0; i < n; i++) begin
      line <= f[i];
      repeat (BIT_CYC) @(posedge hclk);
    end
    // Only one stop bit, so a following frame may start at once
    // A low stop bit is released so the line idles high again
    if (!stop_v) begin
      line <= 1'b1;
    end
  endtask
endmodule

// *** tb/asrc_top_bench.sv ***
`timescale 1ns/1ps
module asrc_top_bench;
  import asrc_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  asrc_word_t  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  asrc_word_t  hwdata;
  logic        hreadyout;
  logic        hresp;
  asrc_word_t  hrdata;
  logic        rx_line;
  logic        tx_line;
  int          failures;
  int          cmp_count;

  asrc_top u_asrc_top (
    .hclk                   (hclk),
    .hresetn                (hresetn),
    .hsel                   (hsel),
    .haddr                  (haddr),
    .htrans                 (htrans),
    .hwrite                 (hwrite),
    .hsize                  (hsize),
    .hwdata                 (hwdata),
    .hready                 (hreadyout),
    .hreadyout              (hreadyout),
    .hresp                  (hresp),
    .hrdata                 (hrdata),
    .serial_receive_input   (rx_line),
    .serial_transmit_output (tx_line)
  );

  // Baud control 0x04 gives eight clocks a bit
  asrc_remote #(.BIT_CYC(8)) u_asrc_remote (
    .hclk (hclk),
    .line (rx_line)
  );

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic close_out();
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input asrc_word_t got, input asrc_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input asrc_byte_t a, input asrc_word_t wd,
                     output asrc_word_t rd, output int nw);
    nw = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      nw++;
      @(posedge hclk);
    end
    rd = hrdata;
  endtask

  task automatic wr(input asrc_byte_t a, input asrc_byte_t d);
    asrc_word_t v;
    int         nw;
    bus(1'b1, a, {24'h0, d}, v, nw);
  endtask

  task automatic rdc(input asrc_byte_t a, input asrc_byte_t e, input int ew);
    asrc_word_t v;
    int         nw;
    bus(1'b0, a, 32'h0, v, nw);
    chk(v, {24'h0, e});
    chk(32'(nw), 32'(ew));
  endtask

  // Error status first, then the buffer
  task automatic rcv(input asrc_byte_t d, input asrc_byte_t err);
    rdc(ASRC_OFF_ERR, err, 2);
    rdc(ASRC_OFF_RBUF, d, 1);
  endtask

  task automatic wait_full();
    asrc_word_t v;
    int         nw;
    for (int i = 0; i < 300; i++) begin
      bus(1'b0, ASRC_OFF_STAT, 32'h0, v, nw);
      if (v[ASRC_STAT_RXFULL] === 1'b1) return;
    end
    chk(v, 32'h2);
  endtask

  task automatic t_reset();
    rdc(ASRC_OFF_MODE, 8'h01, 1);
    rdc(ASRC_OFF_BRC, 8'h1f, 1);
    rdc(ASRC_OFF_ERR, 8'h00, 2);
    rdc(ASRC_OFF_STAT, 8'h00, 1);
    rdc(8'h18, 8'h00, 1);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic t_modes();
    asrc_byte_t md;
    wr(ASRC_OFF_BRC, 8'h04);
    for (int m = 0; m < 4; m++) begin
      md = 8'h85 | 8'(m << 3);
      wr(ASRC_OFF_MODE, md);
      repeat (2) @(posedge hclk);
      wr(ASRC_OFF_MODE, md | 8'h20);
      u_asrc_remote.send(8'h3c, 2'(m), 1'b1, 1'b1);
      rcv(8'h3c, (m > 1) ? 8'h04 : 8'h00);
      if (m < 3) begin
        wr(ASRC_OFF_MODE, md);
      end
    end
    u_asrc_remote.send(8'ha5, 2'h3, 1'b0, 1'b1);
    rcv(8'ha5, 8'h00);
  endtask

  task automatic t_framing();
    u_asrc_remote.send(8'h55, 2'h3, 1'b0, 1'b0);
    repeat (10) @(posedge hclk);
    rcv(8'h55, 8'h02);
  endtask

  // Two stop bits set, yet a frame right after one stop bit must pass
  task automatic t_stop2();
    wr(ASRC_OFF_MODE, 8'hbf);
    fork
      begin
        u_asrc_remote.send(8'h5a, 2'h3, 1'b0, 1'b1);
        u_asrc_remote.send(8'hc3, 2'h3, 1'b0, 1'b1);
      end
      begin
        wait_full();
        rcv(8'h5a, 8'h00);
      end
    join
    repeat (4) @(posedge hclk);
    rcv(8'hc3, 8'h00);
  endtask

  task automatic t_overrun();
    u_asrc_remote.send(8'h11, 2'h3, 1'b0, 1'b1);
    u_asrc_remote.send(8'h22, 2'h3, 1'b0, 1'b1);
    u_asrc_remote.send(8'h33, 2'h3, 1'b0, 1'b1);
    repeat (4) @(posedge hclk);
    rcv(8'h11, 8'h01);
    rdc(ASRC_OFF_STAT, 8'h00, 1);
  endtask

  // Seven data bits: bit seven of the byte lands in the parity slot, set wrong
  task automatic t_char7();
    wr(ASRC_OFF_MODE, 8'h9f);
    wr(ASRC_OFF_MODE, 8'h9b);
    repeat (2) @(posedge hclk);
    wr(ASRC_OFF_MODE, 8'hbb);
    u_asrc_remote.send(8'hab, 2'h0, 1'b0, 1'b1);
    rcv(8'h2b, 8'h04);
    wr(ASRC_OFF_MODE, 8'h9b);
    wr(ASRC_OFF_MODE, 8'h9f);
  endtask

  // Enable while the line is already low: the frame is taken at once
  task automatic t_low_enable();
    wr(ASRC_OFF_MODE, 8'h9f);
    repeat (2) @(posedge hclk);
    fork
      wr(ASRC_OFF_MODE, 8'hbf);
      begin
        repeat (2) @(posedge hclk);
        u_asrc_remote.send(8'h96, 2'h3, 1'b0, 1'b1);
      end
    join
    repeat (4) @(posedge hclk);
    rcv(8'h96, 8'h00);
  endtask

  task automatic t_baud();
    int          n;
    logic [10:0] fr;
    n = 0;
    wr(ASRC_OFF_MODE, 8'hff);
    repeat (2) @(posedge hclk);
    wr(ASRC_OFF_TXD, 8'h01);
    for (int i = 0; i < 40 && tx_line !== 1'b0; i++) @(posedge hclk);
    while (tx_line === 1'b0 && n < 40) begin
      n++;
      @(posedge hclk);
    end
    chk(32'(n), 32'h8);
    // Mid-bit samples: eight data bits, even parity, two stop bits
    repeat (4) @(posedge hclk);
    for (int j = 0; j < 11; j++) begin
      fr[j] = tx_line;
      repeat (8) @(posedge hclk);
    end
    chk(32'(fr), 32'h701);
  endtask

  initial begin
    failures  = 0;
    cmp_count = 0;
    hresetn   = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_modes();
    t_framing();
    t_stop2();
    t_overrun();
    t_char7();
    t_low_enable();
    t_baud();
    close_out();
  end

  // A hung handshake ends the run as a failure
  initial begin
    repeat (30000) @(posedge hclk);
    failures++;
    close_out();
  end
endmodule
